//--- logic/slrt_defs.svh
// Purpose: Register offsets, field positions, reset values and counts for the rx test checkers
// Assumes: 12-bit byte-wide register address space
// Notes:   Definitions only
`ifndef SLRT_DEFS_SVH
`define SLRT_DEFS_SVH

`define SLRT_A_PRBS_EN    12'h315
`define SLRT_A_PRBS_CTL   12'h316
`define SLRT_A_THR0       12'h317
`define SLRT_A_THR1       12'h318
`define SLRT_A_THR2       12'h319
`define SLRT_A_CNT0       12'h31A
`define SLRT_A_CNT1       12'h31B
`define SLRT_A_CNT2       12'h31C
`define SLRT_A_PASS       12'h31D
`define SLRT_A_SMP_CTL    12'h32C
`define SLRT_A_REF0       12'h32D
`define SLRT_A_REF1       12'h32E
`define SLRT_A_SMP_RES    12'h32F
`define SLRT_A_CGS_STAT   12'h470
`define SLRT_A_ILAS_CTL   12'h477
`define SLRT_A_LINK_EN    12'h47D

`define SLRT_B_PRBS_RST   0
`define SLRT_B_PRBS_START 1
`define SLRT_B_PAT_LSB    2
`define SLRT_B_LSEL_LSB   4
`define SLRT_B_SMP_EN     0
`define SLRT_B_SMP_RST    1
`define SLRT_B_CONV_LSB   2
`define SLRT_B_SLOT_LSB   4
`define SLRT_B_ILAS_MODE  7

`define SLRT_M_PRBS_CTL   8'h7F
`define SLRT_M_SMP_CTL    8'h3F
`define SLRT_RST_BYTE     8'h00
`define SLRT_PAT_PRBS7    2'h0
`define SLRT_PAT_PRBS15   2'h1
`define SLRT_PAT_PRBS31   2'h2
`define SLRT_K28_5        8'hBC
`define SLRT_CGS_COUNT    3'h4
`define SLRT_LOCK_WORDS   3'h4

`endif

//--- logic/slrt_pkg.sv
// Purpose: Types shared by the rx test checkers
// Assumes: slrt_defs.svh holds the encodings
// Notes:   Pattern encoding follows the pattern-select field
`include "slrt_defs.svh"
package slrt_pkg;
  typedef enum logic [1:0] {
    SLRT_PRBS7  = `SLRT_PAT_PRBS7,
    SLRT_PRBS15 = `SLRT_PAT_PRBS15,
    SLRT_PRBS31 = `SLRT_PAT_PRBS31
  } slrt_pat_t;
endpackage

//--- logic/slrt_checkers.sv
// Purpose: PRBS lane checker, transport sample checker and code-group check of a 4-lane receiver
// Assumes: Lane and sample inputs synchronous to i_mclk; register port reads one cycle late
// Notes:   Sample stream passes through a small FIFO and an output register on its way on
`timescale 1ns/10ps
`include "slrt_defs.svh"

module slrt_fifo #(
  parameter int W = 20,
  parameter int D = 4
)(
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  // Fill side
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  // Drain side
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
    logic                empty;
  } slrt_fifo_st_t;

  slrt_fifo_st_t st_r;
  slrt_fifo_st_t st_nxt;
  logic          push;
  logic          pop;

  assign push    = i_valid & st_r.rdy;
  assign pop     = i_ready & ~st_r.empty;
  assign o_ready = st_r.rdy;
  assign o_valid = ~st_r.empty;
  assign o_data  = st_r.mem[st_r.rp];

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = i_data;
      st_nxt.wp = (st_r.wp == AW'(D - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(D - 1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt   = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Ready is kept as a flop so the port needs no gate after the register
    st_nxt.rdy   = (st_nxt.cnt != (AW + 1)'(D));
    st_nxt.empty = (st_nxt.cnt == '0);
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r       <= '0;
      st_r.empty <= 1'b1;
      st_r.rdy   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // slrt_fifo

// Notes on behaviour
// - PRBS checker self-locks, needs no link
// - Pattern select picks PRBS7, PRBS15, PRBS31
// - Per-lane enable bits gate PRBS checking
// - Checker reset bit clears PRBS state
// - 24-bit error threshold over three bytes
// - Test starts on start bit rising edge
// - Pass register gives one bit per lane
// - Lane select picks visible error count
// - Error counters saturate at all ones
// - Counts kept for all lanes, one shown
// - Only selected converter and slot compared
// - 16-bit reference compared to received sample
// - Sample compare only while enabled
// - Sample checker reset pulse clears result
// - Result bit 1 on mismatch, 0 on match
// - K28.5 stream releases sync request, status
// - Lane alignment test mode: four K28.5 release
module slrt_checkers
  import slrt_pkg::*;
#(
  parameter int LANES  = 4,
  parameter int SMP_W  = 16,
  parameter int FIFO_D = 4
)(
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_b,
  // Register port
  input  wire logic [11:0]        i_reg_addr,
  input  wire logic               i_reg_wr,
  input  wire logic [7:0]         i_reg_wdata,
  output logic [7:0]              o_reg_rdata,
  // Raw lane words, bit 0 first
  input  wire logic [LANES-1:0]   i_phy_valid,
  input  wire logic [LANES*8-1:0] i_phy_word,
  // Decoded lane characters
  input  wire logic [LANES-1:0]   i_cgs_valid,
  input  wire logic [LANES-1:0]   i_cgs_is_k,
  input  wire logic [LANES*8-1:0] i_cgs_char,
  // Received converter samples
  input  wire logic               i_smp_valid,
  input  wire logic [1:0]         i_smp_conv,
  input  wire logic [1:0]         i_smp_slot,
  input  wire logic [SMP_W-1:0]   i_smp_data,
  output logic                    o_smp_ready,
  // Samples onward
  output logic                    o_out_valid,
  output logic [SMP_W-1:0]        o_out_data,
  input  wire logic               i_out_ready,
  // Link
  output logic                    o_sync_req_b
);
  localparam int FW = SMP_W + 4;
  localparam logic [7:0] LMASK = 8'((1 << LANES) - 1);

  typedef struct packed {
    logic [7:0]                  lane_en;
    logic [7:0]                  ctl;
    logic [23:0]                 thr;
    logic [7:0]                  sctl;
    logic [15:0]                 refv;
    logic                        ilas;
    logic [7:0]                  link_en;
    logic                        start_q;
    logic [LANES-1:0][30:0]      hist;
    logic [LANES-1:0][2:0]       lock;
    logic [LANES-1:0][23:0]      cnt;
    logic [LANES-1:0][2:0]       kcnt;
    logic [LANES-1:0]            cgs_ok;
    logic                        fail;
    logic                        sync_b;
    logic                        out_valid;
    logic [SMP_W-1:0]            out_data;
    logic [7:0]                  rdata;
  } slrt_st_t;

  slrt_st_t               st_r;
  slrt_st_t               st_nxt;
  slrt_pat_t              pat;
  logic [LANES-1:0][30:0] hist_new;
  logic [LANES-1:0][3:0]  err_bits;
  logic [LANES-1:0]       k28;
  logic [LANES-1:0]       pass;
  logic                   f_valid;
  logic [FW-1:0]          f_data;
  logic                   drain;

  assign pat = slrt_pat_t'(st_r.ctl[`SLRT_B_PAT_LSB +: 2]);
  assign drain = ~st_r.out_valid | i_out_ready;

  // Each expected bit is predicted from the received bits themselves, so the
  // checker locks onto any phase of the pattern without frame alignment
  for (genvar gl = 0; gl < LANES; gl++) begin : g_lane
    logic [30:0] h;
    logic [3:0]  e;
    logic        x;
    always_comb begin
      h = st_r.hist[gl];
      e = 4'h0;
      x = 1'b0;
      for (int b = 0; b < 8; b++) begin
        case (pat)
          SLRT_PRBS15: x = h[14] ^ h[13];
          SLRT_PRBS31: x = h[30] ^ h[27];
          default:     x = h[6] ^ h[5];
        endcase
        e = e + {3'h0, x ^ i_phy_word[gl*8+b]};
        h = {h[29:0], i_phy_word[gl*8+b]};
      end
    end
    assign hist_new[gl] = h;
    assign err_bits[gl] = e;
    assign k28[gl] = i_cgs_valid[gl] & i_cgs_is_k[gl]
                   & (i_cgs_char[gl*8 +: 8] == `SLRT_K28_5);
    assign pass[gl] = st_r.lane_en[gl] & (st_r.lock[gl] == `SLRT_LOCK_WORDS)
                    & (st_r.cnt[gl] <= st_r.thr);
  end

  slrt_fifo #(
    .W (FW),
    .D (FIFO_D)
  ) u_fifo (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_valid (i_smp_valid),
    .o_ready (o_smp_ready),
    .i_data  ({i_smp_conv, i_smp_slot, i_smp_data}),
    .o_valid (f_valid),
    .i_ready (drain),
    .o_data  (f_data)
  );

  always_comb begin
    logic        clr_all;
    logic        start_edge;
    logic [23:0] base;
    logic [3:0]  add;
    logic [24:0] sum;
    logic [2:0]  kn;
    logic [2:0]  lsel;
    logic        hit;
    clr_all    = st_r.ctl[`SLRT_B_PRBS_RST];
    start_edge = st_r.ctl[`SLRT_B_PRBS_START] & ~st_r.start_q;
    base       = 24'h0;
    add        = 4'h0;
    sum        = 25'h0;
    kn         = 3'h0;
    lsel       = st_r.ctl[`SLRT_B_LSEL_LSB +: 3];
    hit        = 1'b0;
    st_nxt     = st_r;

    if (i_reg_wr) begin
      if (i_reg_addr == `SLRT_A_PRBS_EN) begin
        st_nxt.lane_en = i_reg_wdata & LMASK;
      end else if (i_reg_addr == `SLRT_A_PRBS_CTL) begin
        st_nxt.ctl = i_reg_wdata & `SLRT_M_PRBS_CTL;
      end else if (i_reg_addr == `SLRT_A_THR0) begin
        st_nxt.thr[7:0] = i_reg_wdata;
      end else if (i_reg_addr == `SLRT_A_THR1) begin
        st_nxt.thr[15:8] = i_reg_wdata;
      end else if (i_reg_addr == `SLRT_A_THR2) begin
        st_nxt.thr[23:16] = i_reg_wdata;
      end else if (i_reg_addr == `SLRT_A_SMP_CTL) begin
        st_nxt.sctl = i_reg_wdata & `SLRT_M_SMP_CTL;
      end else if (i_reg_addr == `SLRT_A_REF0) begin
        st_nxt.refv[7:0] = i_reg_wdata;
      end else if (i_reg_addr == `SLRT_A_REF1) begin
        st_nxt.refv[15:8] = i_reg_wdata;
      end else if (i_reg_addr == `SLRT_A_ILAS_CTL) begin
        st_nxt.ilas = i_reg_wdata[`SLRT_B_ILAS_MODE];
      end else if (i_reg_addr == `SLRT_A_LINK_EN) begin
        st_nxt.link_en = i_reg_wdata & LMASK;
      end
    end

    st_nxt.start_q = st_r.ctl[`SLRT_B_PRBS_START];

    for (int l = 0; l < LANES; l++) begin
      if (clr_all || !st_r.lane_en[l]) begin
        st_nxt.lock[l] = 3'h0;
        st_nxt.hist[l] = 31'h0;
      end else if (i_phy_valid[l]) begin
        st_nxt.hist[l] = hist_new[l];
        if (st_r.lock[l] != `SLRT_LOCK_WORDS) begin
          st_nxt.lock[l] = st_r.lock[l] + 3'h1;
        end
      end
      // Counts restart at reset or a new start, otherwise hold after the test
      base = (clr_all || start_edge) ? 24'h0 : st_r.cnt[l];
      add  = (st_r.ctl[`SLRT_B_PRBS_START] && !clr_all && st_r.lane_en[l]
              && i_phy_valid[l] && st_r.lock[l] == `SLRT_LOCK_WORDS)
             ? err_bits[l] : 4'h0;
      sum  = {1'b0, base} + {21'h0, add};
      st_nxt.cnt[l] = sum[24] ? 24'hFFFFFF : sum[23:0];

      if (!st_r.link_en[l]) begin
        kn = 3'h0;
      end else if (i_cgs_valid[l]) begin
        if (k28[l]) begin
          kn = (st_r.kcnt[l] == `SLRT_CGS_COUNT) ? st_r.kcnt[l] : st_r.kcnt[l] + 3'h1;
        end else begin
          kn = 3'h0;
        end
      end else begin
        kn = st_r.kcnt[l];
      end
      st_nxt.kcnt[l] = kn;
      // In alignment test mode the pass latches, since other characters follow
      st_nxt.cgs_ok[l] = st_r.link_en[l]
                       & ((kn == `SLRT_CGS_COUNT) | (st_r.ilas & st_r.cgs_ok[l]));
    end

    st_nxt.sync_b = (st_r.link_en != 8'h00)
                  & ((st_r.cgs_ok | ~st_r.link_en[LANES-1:0]) == {LANES{1'b1}});

    if (drain) begin
      st_nxt.out_valid = f_valid;
      if (f_valid) begin
        st_nxt.out_data = f_data[SMP_W-1:0];
      end
    end
    hit = drain && f_valid && st_r.sctl[`SLRT_B_SMP_EN]
        && f_data[SMP_W+3 -: 2] == st_r.sctl[`SLRT_B_CONV_LSB +: 2]
        && f_data[SMP_W+1 -: 2] == st_r.sctl[`SLRT_B_SLOT_LSB +: 2]
        && f_data[SMP_W-1:0] != st_r.refv;
    // A mismatch in the cycle of a clear still sets the flag
    if (hit) begin
      st_nxt.fail = 1'b1;
    end else if (st_r.sctl[`SLRT_B_SMP_RST]) begin
      st_nxt.fail = 1'b0;
    end

    if (i_reg_addr == `SLRT_A_PRBS_EN) begin
      st_nxt.rdata = st_r.lane_en;
    end else if (i_reg_addr == `SLRT_A_PRBS_CTL) begin
      st_nxt.rdata = st_r.ctl;
    end else if (i_reg_addr == `SLRT_A_THR0) begin
      st_nxt.rdata = st_r.thr[7:0];
    end else if (i_reg_addr == `SLRT_A_THR1) begin
      st_nxt.rdata = st_r.thr[15:8];
    end else if (i_reg_addr == `SLRT_A_THR2) begin
      st_nxt.rdata = st_r.thr[23:16];
    end else if (i_reg_addr == `SLRT_A_CNT0 && int'(lsel) < LANES) begin
      st_nxt.rdata = st_r.cnt[lsel[1:0]][7:0];
    end else if (i_reg_addr == `SLRT_A_CNT1 && int'(lsel) < LANES) begin
      st_nxt.rdata = st_r.cnt[lsel[1:0]][15:8];
    end else if (i_reg_addr == `SLRT_A_CNT2 && int'(lsel) < LANES) begin
      st_nxt.rdata = st_r.cnt[lsel[1:0]][23:16];
    end else if (i_reg_addr == `SLRT_A_PASS) begin
      st_nxt.rdata = {{(8-LANES){1'b0}}, pass};
    end else if (i_reg_addr == `SLRT_A_SMP_CTL) begin
      st_nxt.rdata = st_r.sctl;
    end else if (i_reg_addr == `SLRT_A_REF0) begin
      st_nxt.rdata = st_r.refv[7:0];
    end else if (i_reg_addr == `SLRT_A_REF1) begin
      st_nxt.rdata = st_r.refv[15:8];
    end else if (i_reg_addr == `SLRT_A_SMP_RES) begin
      st_nxt.rdata = {7'h0, st_r.fail};
    end else if (i_reg_addr == `SLRT_A_CGS_STAT) begin
      st_nxt.rdata = {{(8-LANES){1'b0}}, st_r.cgs_ok};
    end else if (i_reg_addr == `SLRT_A_ILAS_CTL) begin
      st_nxt.rdata = {st_r.ilas, 7'h0};
    end else if (i_reg_addr == `SLRT_A_LINK_EN) begin
      st_nxt.rdata = st_r.link_en;
    end else begin
      st_nxt.rdata = `SLRT_RST_BYTE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata  = st_r.rdata;
  assign o_out_valid  = st_r.out_valid;
  assign o_out_data   = st_r.out_data;
  assign o_sync_req_b = st_r.sync_b;
endmodule // slrt_checkers

//--- testbench/slrt_far_tx.sv
// Purpose: Far-side transmitter model: PRBS lanes, K28.5 characters, test samples
// Assumes: Lane words leave bit 0 first; four sample slots (two converters, two samples)
// Notes:   i_err flips bit 0 of a lane word for one cycle
`timescale 1ns/10ps
module slrt_far_tx (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  // Test controls
  input  wire logic [1:0]  i_pat,
  input  wire logic [3:0]  i_err,
  input  wire logic [15:0] i_base,
  // Lanes
  output logic [3:0]       o_phy_valid,
  output logic [31:0]      o_phy_word,
  output logic [3:0]       o_cgs_valid,
  output logic [3:0]       o_cgs_is_k,
  output logic [31:0]      o_cgs_char,
  // Samples
  output logic             o_smp_valid,
  output logic [1:0]       o_smp_conv,
  output logic [1:0]       o_smp_slot,
  output logic [15:0]      o_smp_data,
  input  wire logic        i_smp_ready
);
  logic [30:0] hist_r;
  logic [1:0]  slot_r;
  logic [38:0] step;

  // Every bit obeys the chosen recurrence, so a pattern switch needs no reseed
  function automatic logic [38:0] gen(input logic [30:0] s0, input logic [1:0] p);
    logic [30:0] s;
    logic [7:0]  w;
    s = s0;
    for (int i = 0; i < 8; i++) begin
      w[i] = (p == 2'h2) ? s[30] ^ s[27] : (p == 2'h1) ? s[14] ^ s[13] : s[6] ^ s[5];
      s = {s[29:0], w[i]};
    end
    return {w, s};
  endfunction

  assign step = gen(hist_r, i_pat);
  assign o_cgs_valid = o_phy_valid;
  assign o_cgs_is_k = o_phy_valid;
  assign o_cgs_char = {4{8'hBC}};
  assign o_smp_conv = {1'b0, slot_r[1]};
  assign o_smp_slot = {1'b0, slot_r[0]};
  // Outside a transfer the data shows garbage rather than a stale value
  assign o_smp_data = o_smp_valid ? i_base + {14'h0000, slot_r} : ~i_base;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hist_r      <= '1;
      slot_r      <= 2'h0;
      o_phy_valid <= 4'h0;
      o_phy_word  <= 32'h0000_0000;
      o_smp_valid <= 1'b0;
    end else begin
      hist_r      <= step[30:0];
      o_phy_valid <= 4'hF;
      o_phy_word  <= {4{step[38:31]}} ^ {7'h00, i_err[3], 7'h00, i_err[2],
                                         7'h00, i_err[1], 7'h00, i_err[0]};
      o_smp_valid <= 1'b1;
      if (o_smp_valid && i_smp_ready) slot_r <= slot_r + 2'h1;
    end
  end
endmodule // slrt_far_tx

//--- testbench/slrt_chk_sva.sv
// Purpose: Port-level assertions for the rx test checkers
// Assumes: Register reads answer one cycle after the address
// Notes:   Shadows of enable bits and of the top lane-select bit track register writes
`timescale 1ns/10ps
module slrt_chk #(
  parameter int SMP_W = 16
)(
  // Clock and reset
  input wire logic             i_mclk,
  input wire logic             i_rst_b,
  // Register port
  input wire logic [11:0]      i_reg_addr,
  input wire logic             i_reg_wr,
  input wire logic [7:0]       i_reg_wdata,
  input wire logic [7:0]       o_reg_rdata,
  // Samples onward and link
  input wire logic             o_out_valid,
  input wire logic [SMP_W-1:0] o_out_data,
  input wire logic             i_out_ready,
  input wire logic             o_sync_req_b
);
  logic [3:0] lane_en_r;
  logic [3:0] link_en_r;
  logic       lsel_hi_r;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lane_en_r <= 4'h0;
      link_en_r <= 4'h0;
      lsel_hi_r <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == 12'h315) lane_en_r <= i_reg_wdata[3:0];
      if (i_reg_addr == 12'h47D) link_en_r <= i_reg_wdata[3:0];
      if (i_reg_addr == 12'h316) lsel_hi_r <= i_reg_wdata[6];
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  ctl_readback_a: assert property (
    i_reg_wr && i_reg_addr == 12'h316 ##1 !i_reg_wr && i_reg_addr == 12'h316
    |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h7F)) else $error("prbs control readback");
  smp_readback_a: assert property (
    i_reg_wr && i_reg_addr == 12'h32C ##1 !i_reg_wr && i_reg_addr == 12'h32C
    |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h3F)) else $error("sample control readback");
  unmapped_zero_a: assert property (
    i_reg_addr == 12'h400 |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  lsel_zero_a: assert property (
    i_reg_addr inside {12'h31A, 12'h31B, 12'h31C} && lsel_hi_r |=> o_reg_rdata == 8'h00)
    else $error("count of absent lane not zero");
  pass_mask_a: assert property (
    i_reg_addr == 12'h31D |=> (o_reg_rdata & ~{4'h0, $past(lane_en_r)}) == 8'h00)
    else $error("pass flag on disabled lane");
  cgs_mask_a: assert property (
    i_reg_addr == 12'h470 |=> (o_reg_rdata & ~{4'h0, $past(link_en_r)}) == 8'h00)
    else $error("code group pass on disabled lane");
  sync_hold_a: assert property (
    $rose(i_rst_b) |-> !o_sync_req_b [*5]) else $error("sync request released too early");
  out_hold_a: assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
    else $error("stalled sample changed");
  sync_idle_a: assert property (
    link_en_r == 4'h0 |=> !o_sync_req_b) else $error("sync released with no lane enabled");
endmodule // slrt_chk

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the rx test checkers
// Assumes: Far-side model sends PRBS, K28.5 and four distinct samples
// Notes:   Reads note the expected byte; a monitor compares it a cycle later
`timescale 1ns/10ps
module tb_top;
  logic        i_mclk      = 1'b0;
  logic        i_rst_b;
  logic [11:0] i_reg_addr  = 12'h000;
  logic        i_reg_wr    = 1'b0;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_out_ready = 1'b0;
  logic [1:0]  pat = 2'h0;
  logic [3:0]  err = 4'h0;
  logic [15:0] base = 16'h0000;
  logic [3:0]  phy_v, cgs_v, cgs_k;
  logic [31:0] phy_w, cgs_c;
  logic        smp_v, o_smp_ready, o_out_valid, o_sync_req_b;
  logic [1:0]  smp_cv, smp_sl;
  logic [15:0] smp_d, o_out_data, rv;
  logic [7:0]  o_reg_rdata, cc, pass_exp;
  int          num_errors = 0;
  int          n_tests = 0;
  int          seed = 62538;
  int          nerr;
  logic        stall = 1'b1;
  logic        rd_pend = 1'b0;
  logic        rd_due = 1'b0;
  logic [11:0] ra_q[$];
  logic [7:0]  re_q[$];
  logic [15:0] sq[$];
  logic [11:0] regs[17] = '{12'h315, 12'h316, 12'h317, 12'h318, 12'h319, 12'h31A, 12'h31B,
    12'h31C, 12'h31D, 12'h32C, 12'h32D, 12'h32E, 12'h32F, 12'h470, 12'h477, 12'h47D, 12'h400};

  always #25 i_mclk = ~i_mclk;

  slrt_checkers slrt_checkers_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_phy_valid(phy_v), .i_phy_word(phy_w),
    .i_cgs_valid(cgs_v), .i_cgs_is_k(cgs_k), .i_cgs_char(cgs_c), .i_smp_valid(smp_v),
    .i_smp_conv(smp_cv), .i_smp_slot(smp_sl), .i_smp_data(smp_d), .o_smp_ready(o_smp_ready),
    .o_out_valid(o_out_valid), .o_out_data(o_out_data), .i_out_ready(i_out_ready),
    .o_sync_req_b(o_sync_req_b));
  slrt_far_tx slrt_far_tx_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_pat(pat),
    .i_err(err), .i_base(base), .o_phy_valid(phy_v), .o_phy_word(phy_w),
    .o_cgs_valid(cgs_v), .o_cgs_is_k(cgs_k), .o_cgs_char(cgs_c), .o_smp_valid(smp_v),
    .o_smp_conv(smp_cv), .o_smp_slot(smp_sl), .o_smp_data(smp_d), .i_smp_ready(o_smp_ready));

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_reg_addr <= a;
    ra_q.push_back(a);
    re_q.push_back(e);
    rd_pend <= 1'b1;
    @(posedge i_mclk);
    rd_pend <= 1'b0;
  endtask

  task automatic inject;
    @(posedge i_mclk);
    err <= 4'h2;
    @(posedge i_mclk);
    err <= 4'h0;
    repeat (8) @(posedge i_mclk);
  endtask

  task automatic close_out;
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    rd_due <= rd_pend;
    if (i_rst_b && smp_v && o_smp_ready) sq.push_back(smp_d);
    if (i_rst_b && o_out_valid && i_out_ready) cmp("sample", sq.pop_front(), o_out_data);
    i_out_ready <= ~stall & 1'($random(seed));
  end

  always @(negedge i_mclk) begin
    if (rd_due) cmp($sformatf("reg %h", ra_q.pop_front()), {8'h00, re_q.pop_front()},
                    {8'h00, o_reg_rdata});
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    cmp("watchdog", 16'h0000, 16'h0001);
    close_out();
  end

  initial begin
    i_rst_b = 1'b0;
    base = 16'($random(seed));
    nerr = 1 + ($random(seed) & 32'h1);
    repeat (5) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    @(negedge i_mclk);
    cmp("buffer ready", 16'h0000, {15'h0000, o_smp_ready});
    stall <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      cc = 8'(p << 2);
      pat <= 2'(p);
      wr(12'h316, cc);
      wr(12'h315, 8'hF7);
      rd(12'h315, 8'h07);
      wr(12'h316, cc | 8'h01);
      wr(12'h316, cc);
      wr(12'h317, 8'h04);
      wr(12'h318, 8'h00);
      wr(12'h319, 8'h00);
      wr(12'h316, cc | 8'h02);
      repeat (10) @(posedge i_mclk);
      repeat (nerr) inject();
      wr(12'h316, cc | 8'h10);
      inject();
      pass_exp = (nerr == 1) ? 8'h07 : 8'h05;
      rd(12'h31D, pass_exp);
      for (int l = 0; l < 5; l++) begin
        wr(12'h316, cc | 8'(l << 4));
        rd(12'h31A, (l == 1) ? 8'(3 * nerr) : 8'h00);
        rd(12'h31B, 8'h00);
      end
    end
    wr(12'h31D, 8'hFF);
    rd(12'h31D, pass_exp);
    wr(12'h32C, 8'hFF);
    rd(12'h32C, 8'h3F);
    for (int i = 0; i < 6; i++) begin
      cc = 8'(((i & 1) << 4) | (((i >> 1) & 1) << 2)) | ((i < 5) ? 8'h01 : 8'h00);
      rv = base + 16'(i & 3) ^ ((i > 3) ? 16'h0001 : 16'h0000);
      wr(12'h32D, rv[7:0]);
      wr(12'h32E, rv[15:8]);
      wr(12'h32C, cc);
      wr(12'h32C, cc | 8'h02);
      wr(12'h32C, cc);
      repeat (24) @(posedge i_mclk);
      rd(12'h32F, (i == 4) ? 8'h01 : 8'h00);
    end
    @(negedge i_mclk);
    cmp("sync", 16'h0000, {15'h0000, o_sync_req_b});
    wr(12'h477, 8'hFF);
    rd(12'h477, 8'h80);
    wr(12'h47D, 8'hFF);
    for (int k = 0; k < 20 && o_sync_req_b !== 1'b1; k++) @(negedge i_mclk);
    cmp("sync", 16'h0001, {15'h0000, o_sync_req_b});
    if (o_sync_req_b === 1'b1) begin
      rd(12'h470, 8'h0F);
      rd(12'h47D, 8'h0F);
      repeat (20) @(posedge i_mclk);
    end
    close_out();
  end
endmodule // tb_top

bind slrt_checkers slrt_chk #(.SMP_W(SMP_W)) slrt_chk_inst (.i_mclk(i_mclk),
  .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_out_valid(o_out_valid),
  .o_out_data(o_out_data), .i_out_ready(i_out_ready), .o_sync_req_b(o_sync_req_b));
